// ===== design/nrp_defs.svh
`ifndef NRP_DEFS_SVH
`define NRP_DEFS_SVH

// clock period
`define NRP_CLK_NS 8
// power-up recovery, least time
`define NRP_POWERUP_US 100
`define NRP_POWERUP_CYC ((`NRP_POWERUP_US * 1000 + `NRP_CLK_NS - 1) / `NRP_CLK_NS)
// strobe low and high phase, least time
`define NRP_STROBE_NS 24
`define NRP_STROBE_CYC ((`NRP_STROBE_NS + `NRP_CLK_NS - 1) / `NRP_CLK_NS)
// wait after the last write strobe before busy is trusted
`define NRP_TWB_NS 100
`define NRP_TWB_CYC ((`NRP_TWB_NS + `NRP_CLK_NS - 1) / `NRP_CLK_NS)
// extra read strobe cycles to cover the data synchroniser
`define NRP_SYNC_CYC 2

// command bytes
`define NRP_CMD_RESET 8'hff
`define NRP_CMD_STATUS 8'h70
`define NRP_CMD_READ_ID 8'h90
`define NRP_ADDR_ID 8'h00

// status and identification layout
`define NRP_STAT_READY_BIT 6
`define NRP_ID_BYTES 5
`define NRP_ID_PAGE_IDX 3
`define NRP_ID_PLANE_IDX 4

`endif

// ===== design/nrp_pkg.sv
package nrp_pkg;

    typedef enum logic [1:0] {
        NRP_OP_RESET,
        NRP_OP_STATUS,
        NRP_OP_READ_ID,
        NRP_OP_NONE
    } nrp_op_t;

    typedef enum logic [3:0] {
        NRP_ST_PWR,
        NRP_ST_IDLE,
        NRP_ST_CMD_LO,
        NRP_ST_CMD_HI,
        NRP_ST_ADR_LO,
        NRP_ST_ADR_HI,
        NRP_ST_WB,
        NRP_ST_WAIT_RB,
        NRP_ST_RD_LO,
        NRP_ST_RD_HI
    } nrp_state_t;

    typedef struct packed {
        nrp_state_t state;
        nrp_op_t op;
        logic [7:0] cnt;
        logic [15:0] up_cnt;
        logic [2:0] idx;
        logic pwr_ok;
        logic cle;
        logic ale;
        logic ce_b;
        logic we_b;
        logic re_b;
        logic wp_b;
        logic [7:0] io_out;
        logic io_oe;
        logic rb_s1;
        logic rb_s2;
        logic [7:0] io_s1;
        logic [7:0] io_s2;
        logic busy;
        logic ready;
        logic done;
        logic cmd_ready;
        logic [7:0] status;
        logic [7:0] page_info;
        logic [7:0] plane_info;
        logic mem_wr;
        logic [2:0] mem_addr;
        logic [7:0] mem_data;
    } nrp_host_t;

endpackage

// ===== design/nrp_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface nrp_mem_if;
    logic wr_en;
    logic [2:0] wr_addr;
    logic [7:0] wr_data;
    logic [2:0] rd_addr;
    logic [7:0] rd_data;

    modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// ===== design/nrp_id_mem.sv
`timescale 1ns/1ps
`default_nettype none

module nrp_id_mem #(
    parameter int DEPTH = 5
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // memory port
    nrp_mem_if.mem mif
);
    logic [7:0] ram [DEPTH];

    always_ff @(posedge ref_clk) begin
        if (mif.wr_en) begin
            ram[mif.wr_addr] <= mif.wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mif.rd_data <= 8'h00;
        end else if (int'(mif.rd_addr) < DEPTH) begin
            mif.rd_data <= ram[mif.rd_addr];
        end else begin
            mif.rd_data <= 8'h00;
        end
    end
endmodule // nrp_id_mem

`default_nettype wire

// ===== design/nrp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "nrp_defs.svh"

module nrp_host
    import nrp_pkg::*;
#(
    parameter int POWERUP_CYC = `NRP_POWERUP_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // user command port
    input wire logic cmd_valid,
    input wire nrp_op_t cmd_op,
    input wire logic wp_release,
    output logic cmd_ready,
    output logic done,
    output logic busy,
    output logic ready,
    output logic [7:0] status,
    output logic [7:0] id_page_info,
    output logic [7:0] id_plane_info,
    input wire logic [2:0] id_rd_addr,
    output logic [7:0] id_rd_data,
    // flash pins
    output logic nand_cle,
    output logic nand_ale,
    output logic nand_ce_b,
    output logic nand_we_b,
    output logic nand_re_b,
    output logic nand_wp_b,
    output logic [7:0] nand_io_out,
    output logic nand_io_oe,
    input wire logic [7:0] nand_io_in,
    input wire logic nand_rb
);
    localparam logic [15:0] UP_END = 16'(POWERUP_CYC);
    localparam logic [7:0] STB_END = 8'(`NRP_STROBE_CYC - 1);
    localparam logic [7:0] RD_END = 8'(`NRP_STROBE_CYC + `NRP_SYNC_CYC - 1);
    localparam logic [7:0] WB_END = 8'(`NRP_TWB_CYC - 1);
    localparam logic [2:0] LAST_ID = 3'(`NRP_ID_BYTES - 1);

    nrp_host_t s;
    nrp_host_t next_s;
    nrp_mem_if mif ();

    nrp_id_mem #(.DEPTH(`NRP_ID_BYTES)) u_id_mem (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .mif(mif)
    );

    assign mif.wr_en = s.mem_wr;
    assign mif.wr_addr = s.mem_addr;
    assign mif.wr_data = s.mem_data;
    assign mif.rd_addr = id_rd_addr;
    assign id_rd_data = mif.rd_data;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.mem_wr = 1'b0;
        next_s.rb_s1 = nand_rb;
        next_s.rb_s2 = s.rb_s1;
        next_s.io_s1 = nand_io_in;
        next_s.io_s2 = s.io_s1;
        next_s.busy = ~s.rb_s2;
        next_s.cnt = s.cnt + 8'h01;
        if (s.up_cnt != UP_END) begin
            next_s.up_cnt = s.up_cnt + 16'h0001;
        end
        case (s.state)
            NRP_ST_PWR: begin
                next_s.wp_b = 1'b0;
                if (s.up_cnt == UP_END) begin
                    next_s.pwr_ok = 1'b1;
                    next_s.state = NRP_ST_IDLE;
                end
            end
            NRP_ST_IDLE, NRP_ST_WAIT_RB: begin
                if (cmd_valid && (s.state == NRP_ST_IDLE || cmd_op == NRP_OP_RESET)) begin
                    // a reset may cut a pending busy wait short
                    next_s.op = cmd_op;
                    next_s.ce_b = 1'b0;
                    next_s.cle = 1'b1;
                    next_s.io_oe = 1'b1;
                    next_s.we_b = 1'b0;
                    next_s.cnt = 8'h00;
                    next_s.idx = 3'h0;
                    next_s.state = NRP_ST_CMD_LO;
                    case (cmd_op)
                        NRP_OP_RESET: next_s.io_out = `NRP_CMD_RESET;
                        NRP_OP_STATUS: next_s.io_out = `NRP_CMD_STATUS;
                        NRP_OP_READ_ID: next_s.io_out = `NRP_CMD_READ_ID;
                        default: begin
                            next_s.state = s.state;
                            next_s.ce_b = s.ce_b;
                            next_s.cle = 1'b0;
                            next_s.io_oe = 1'b0;
                            next_s.we_b = 1'b1;
                        end
                    endcase
                end else if (s.state == NRP_ST_WAIT_RB) begin
                    if (s.rb_s2) begin
                        next_s.ce_b = 1'b1;
                        next_s.done = 1'b1;
                        next_s.state = NRP_ST_IDLE;
                    end
                end else begin
                    next_s.wp_b = wp_release;
                end
            end
            NRP_ST_CMD_LO, NRP_ST_ADR_LO: begin
                if (s.cnt == STB_END) begin
                    next_s.we_b = 1'b1;
                    next_s.cnt = 8'h00;
                    next_s.state = (s.state == NRP_ST_CMD_LO) ? NRP_ST_CMD_HI : NRP_ST_ADR_HI;
                end
            end
            NRP_ST_CMD_HI: begin
                if (s.cnt == STB_END) begin
                    next_s.cle = 1'b0;
                    next_s.cnt = 8'h00;
                    if (s.op == NRP_OP_READ_ID) begin
                        next_s.ale = 1'b1;
                        next_s.io_out = `NRP_ADDR_ID;
                        next_s.we_b = 1'b0;
                        next_s.state = NRP_ST_ADR_LO;
                    end else begin
                        next_s.io_oe = 1'b0;
                        next_s.state = NRP_ST_WB;
                    end
                end
            end
            NRP_ST_ADR_HI: begin
                if (s.cnt == STB_END) begin
                    next_s.ale = 1'b0;
                    next_s.io_oe = 1'b0;
                    next_s.cnt = 8'h00;
                    next_s.state = NRP_ST_WB;
                end
            end
            NRP_ST_WB: begin
                if (s.cnt == WB_END) begin
                    next_s.cnt = 8'h00;
                    if (s.op == NRP_OP_RESET) begin
                        next_s.state = NRP_ST_WAIT_RB;
                    end else begin
                        next_s.re_b = 1'b0;
                        next_s.state = NRP_ST_RD_LO;
                    end
                end
            end
            NRP_ST_RD_LO: begin
                if (s.cnt == RD_END) begin
                    next_s.re_b = 1'b1;
                    next_s.cnt = 8'h00;
                    next_s.state = NRP_ST_RD_HI;
                    if (s.op == NRP_OP_STATUS) begin
                        next_s.status = s.io_s2;
                        next_s.ready = s.io_s2[`NRP_STAT_READY_BIT];
                    end else begin
                        next_s.mem_wr = 1'b1;
                        next_s.mem_addr = s.idx;
                        next_s.mem_data = s.io_s2;
                        if (s.idx == 3'(`NRP_ID_PAGE_IDX)) begin
                            next_s.page_info = s.io_s2;
                        end
                        if (s.idx == 3'(`NRP_ID_PLANE_IDX)) begin
                            next_s.plane_info = s.io_s2;
                        end
                    end
                end
            end
            NRP_ST_RD_HI: begin
                if (s.cnt == STB_END) begin
                    next_s.cnt = 8'h00;
                    if (s.op == NRP_OP_STATUS || s.idx == LAST_ID) begin
                        next_s.ce_b = 1'b1;
                        next_s.done = 1'b1;
                        next_s.state = NRP_ST_IDLE;
                    end else begin
                        next_s.idx = s.idx + 3'h1;
                        next_s.re_b = 1'b0;
                        next_s.state = NRP_ST_RD_LO;
                    end
                end
            end
            default: begin
                next_s.state = NRP_ST_IDLE;
            end
        endcase
        next_s.cmd_ready = (next_s.state == NRP_ST_IDLE) || (next_s.state == NRP_ST_WAIT_RB);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.state <= NRP_ST_PWR;
            s.op <= NRP_OP_NONE;
            s.ce_b <= 1'b1;
            s.we_b <= 1'b1;
            s.re_b <= 1'b1;
            s.rb_s1 <= 1'b1;
            s.rb_s2 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign cmd_ready = s.cmd_ready;
    assign done = s.done;
    assign busy = s.busy;
    assign ready = s.ready;
    assign status = s.status;
    assign id_page_info = s.page_info;
    assign id_plane_info = s.plane_info;
    assign nand_cle = s.cle;
    assign nand_ale = s.ale;
    assign nand_ce_b = s.ce_b;
    assign nand_we_b = s.we_b;
    assign nand_re_b = s.re_b;
    assign nand_wp_b = s.wp_b;
    assign nand_io_out = s.io_out;
    assign nand_io_oe = s.io_oe;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_reset_byte: assert property ((s.state == NRP_ST_CMD_LO && s.op == NRP_OP_RESET)
        |-> (s.io_out == 8'hff && s.cle && s.io_oe && !s.we_b))
        else $error("reset command byte not ffh in command cycle");
    a_busy_shared: assert property (!s.rb_s2 |=> busy)
        else $error("low ready/busy line not seen as busy");
    a_pwr_wait: assert property (!nand_we_b |-> (s.pwr_ok && s.up_cnt == UP_END))
        else $error("write strobe before power-up recovery");
    a_wp_steady: assert property (s.state != NRP_ST_IDLE |-> $stable(nand_wp_b))
        else $error("write protect moved outside idle");
    a_wp_powerup: assert property (!s.pwr_ok |-> !nand_wp_b)
        else $error("write protect released during power-up");
    a_status_cmd: assert property ((s.state == NRP_ST_CMD_LO && s.op == NRP_OP_STATUS)
        |-> s.io_out == 8'h70)
        else $error("status command byte not 70h");
    a_status_bit: assert property ((done && s.op == NRP_OP_STATUS) |-> ready == status[6])
        else $error("ready flag does not follow status bit 6");
    a_rb_wait: assert property ((s.state == NRP_ST_WAIT_RB && !s.rb_s2 && !cmd_valid)
        |=> s.state == NRP_ST_WAIT_RB)
        else $error("left busy wait while line low");
    a_rb_done: assert property ((s.state == NRP_ST_WAIT_RB && s.rb_s2 && !cmd_valid)
        |=> (done && s.state == NRP_ST_IDLE))
        else $error("busy wait not ended when line high");

    c_reset_done: cover property (s.op == NRP_OP_RESET && done);
    c_status_done: cover property (s.op == NRP_OP_STATUS && done);
    c_id_done: cover property (s.op == NRP_OP_READ_ID && done);
    c_reset_abort: cover property (s.state == NRP_ST_WAIT_RB && cmd_valid && cmd_op == NRP_OP_RESET);
endmodule // nrp_host

`default_nettype wire

// ===== tb/nrp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

module nrp_flash_model #(
    parameter int UP = 20,
    parameter int T_RST = 30,
    parameter logic [39:0] ID = 40'h0
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // flash pins
    input wire logic cle,
    input wire logic ale,
    input wire logic ce_b,
    input wire logic we_b,
    input wire logic re_b,
    input wire logic wp_b,
    input wire logic [7:0] io,
    output logic rb_pull,
    output logic io_en,
    output logic [7:0] io_q,
    // host misuse flag
    output logic viol
);
    logic [7:0] cmd;
    logic [7:0] stat;
    logic [7:0] bcnt;
    logic [15:0] up;
    logic we_q;
    logic re_q;
    logic id_mode;
    logic [2:0] idx;
    logic wp_q;
    // set when a reset cuts a program or erase short
    logic lost;

    assign rb_pull = bcnt != 8'h00;
    assign io_en = !ce_b && !re_b;
    assign io_q = id_mode ? ID[39 - 8 * idx -: 8] : {stat[7], bcnt == 8'h00, stat[5:0]};

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd <= 8'h00;
            stat <= 8'hc0;
            bcnt <= 8'h00;
            up <= 16'h0000;
            we_q <= 1'b1;
            re_q <= 1'b1;
            id_mode <= 1'b0;
            idx <= 3'h0;
            viol <= 1'b0;
            wp_q <= 1'b0;
            lost <= 1'b0;
        end else begin
            we_q <= we_b;
            re_q <= re_b;
            wp_q <= wp_b;
            if (wp_b != wp_q && bcnt != 8'h00) viol <= 1'b1;
            if (up != 16'(UP)) up <= up + 16'h0001;
            if (bcnt != 8'h00) bcnt <= bcnt - 8'h01;
            if (re_b && !re_q && id_mode) idx <= idx + 3'h1;
            if (we_b && !we_q && !ce_b) begin
                if (cle) begin
                    if (up != 16'(UP) || (bcnt != 8'h00 && io != 8'hff)) viol <= 1'b1;
                    cmd <= io;
                    id_mode <= 1'b0;
                    if (io == 8'hff) begin
                        bcnt <= 8'(T_RST);
                        stat <= {wp_b, 1'b1, 6'h00};
                        lost <= bcnt != 8'h00 && (cmd == 8'h10 || cmd == 8'hd0);
                    end else if (io == 8'h10 || io == 8'hd0 || io == 8'h30) begin
                        bcnt <= 8'(T_RST);
                    end
                end else if (ale && cmd == 8'h90) begin
                    id_mode <= io == 8'h00;
                    idx <= 3'h0;
                end
            end
        end
    end
endmodule // nrp_flash_model

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(name, exp, got) begin compares++; if ((got) !== (exp)) begin failures++; \
    $display("BAD %s exp %h got %h", name, exp, got); end end

module testbench;
    import nrp_pkg::*;
    localparam int PWR = 20;
    localparam int RST_LEN = 30;
    // arbitrary identification bytes
    localparam logic [39:0] ID = 40'h3c5a216b17;
    logic ref_clk = 0, rst_b = 0, cmd_valid = 0, wp_release = 0, other_pull = 0;
    nrp_op_t cmd_op = NRP_OP_NONE;
    logic [2:0] id_rd_addr = 3'h0;
    logic cmd_ready, done, busy, ready, cle, ale, ce_b, we_b, re_b, wp_b, io_oe;
    logic rb_pull, io_en, viol;
    logic [7:0] status, page_info, plane_info, id_rd_data, io_out, io_q, io_bus;
    int failures = 0, compares = 0, cyc = 0, rb_lows = 0;

    assign io_bus = io_oe ? io_out : (io_en ? io_q : cyc[7:0]);

    nrp_host #(.POWERUP_CYC(PWR)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .wp_release(wp_release), .cmd_ready(cmd_ready), .done(done),
        .busy(busy), .ready(ready), .status(status), .id_page_info(page_info),
        .id_plane_info(plane_info), .id_rd_addr(id_rd_addr), .id_rd_data(id_rd_data),
        .nand_cle(cle), .nand_ale(ale), .nand_ce_b(ce_b), .nand_we_b(we_b), .nand_re_b(re_b),
        .nand_wp_b(wp_b), .nand_io_out(io_out), .nand_io_oe(io_oe), .nand_io_in(io_bus),
        .nand_rb(!(rb_pull || other_pull)));

    nrp_flash_model #(.UP(PWR), .T_RST(RST_LEN), .ID(ID)) flash (.ref_clk(ref_clk),
        .rst_b(rst_b), .cle(cle), .ale(ale), .ce_b(ce_b), .we_b(we_b), .re_b(re_b),
        .wp_b(wp_b), .io(io_bus), .rb_pull(rb_pull), .io_en(io_en), .io_q(io_q), .viol(viol));

    always #4 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (rb_pull || other_pull) rb_lows = rb_lows + 1;
        if (cyc == 5000) begin
            failures = failures + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic issue(input nrp_op_t op);
        @(posedge ref_clk);
        #1;
        cmd_valid = 1;
        cmd_op = op;
        while (cmd_ready !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        #1;
        cmd_valid = 0;
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `CHK("done", 1'b1, done)
    endtask

    task automatic t_powerup();
        repeat (PWR - 1) begin
            @(posedge ref_clk);
            #1;
            `CHK("wp_b", 1'b0, wp_b)
            `CHK("cmd_ready", 1'b0, cmd_ready)
        end
    endtask

    task automatic t_reset();
        wp_release = 1;
        rb_lows = 0;
        // protect is only lifted in an idle cycle with no request pending
        while (cmd_ready !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
        @(posedge ref_clk);
        #1;
        `CHK("wp_b_idle", 1'b1, wp_b)
        issue(NRP_OP_RESET);
        wait_done();
        `CHK("rb_lows", RST_LEN, rb_lows)
        `CHK("wp_b", 1'b1, wp_b)
        issue(NRP_OP_STATUS);
        wait_done();
        `CHK("status", 8'hc0, status)
        `CHK("ready", 1'b1, ready)
    endtask

    task automatic t_rereset();
        rb_lows = 0;
        issue(NRP_OP_RESET);
        repeat (25) @(posedge ref_clk);
        issue(NRP_OP_RESET);
        wait_done();
        `CHK("longer_busy", 1'b1, rb_lows > RST_LEN + 10)
        `CHK("host_order", 1'b0, viol)
    endtask

    task automatic t_read_id();
        issue(NRP_OP_READ_ID);
        wait_done();
        `CHK("page_info", ID[15:8], page_info)
        `CHK("plane_info", ID[7:0], plane_info)
        for (int i = 0; i < 6; i++) begin
            id_rd_addr = 3'(i);
            @(posedge ref_clk);
            #1;
            `CHK("id_byte", (i < 5) ? ID[39 - 8 * i -: 8] : 8'h00, id_rd_data)
        end
    endtask

    task automatic t_wired();
        // an idle request with no operation must not start a command cycle
        cmd_op = NRP_OP_NONE;
        cmd_valid = 1;
        other_pull = 1;
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK("busy_low_line", 1'b1, busy)
        `CHK("no_cmd_cycle", 1'b1, ce_b)
        cmd_valid = 0;
        other_pull = 0;
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK("busy_high_line", 1'b0, busy)
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        #1;
        rst_b = 1;
        t_powerup();
        t_reset();
        t_rereset();
        t_read_id();
        t_wired();
        final_report();
    end
endmodule // testbench

`default_nettype wire
